//--- gim_core.sv
`timescale 1ns/1ps
`include "gim_defines.svh"

module gim_core
    import gim_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic acc_cs,
    input wire logic acc_we,
    input wire logic [`GIM_ADDR_W-1:0] acc_addr,
    input wire gim_byte_t acc_wdata,
    output gim_byte_t acc_rdata,
    output logic acc_rvalid,
    input wire logic rd_status_one,
    input wire logic rd_rx_data,
    input wire gim_lsn_s lsn,
    input wire gim_evt_two_s evt,
    input wire gim_grp_one_s grp_one,
    input wire gim_grp_one_s grp_one_en,
    input wire logic rx_byte_flag_en,
    output logic rx_byte_flag,
    output logic dma_rx_req,
    output logic dma_tx_req,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // access decode

    gim_acc_e acc_reg;
    gim_acc_e acc_next;
    logic hit_status;
    logic hit_mask;
    logic rd_hold;
    logic rd_done;
    logic rd_take;
    logic evt_hold;

    assign hit_status = (acc_addr == `GIM_OFS_STATUS_TWO);
    assign hit_mask = (acc_addr == `GIM_OFS_MASK_TWO);

    always_comb
    begin
        acc_next = acc_reg;
        case (acc_reg)
            GIM_ACC_IDLE:
            begin
                if (acc_cs && !acc_we && hit_status)
                    acc_next = GIM_ACC_READ;
                else if (acc_cs && acc_we && hit_mask)
                    acc_next = GIM_ACC_WRITE;
            end
            GIM_ACC_READ:
            begin
                if (!acc_cs)
                    acc_next = GIM_ACC_IDLE;
            end
            GIM_ACC_WRITE:
            begin
                if (!acc_cs)
                    acc_next = GIM_ACC_IDLE;
            end
            default:
                acc_next = GIM_ACC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            acc_reg <= GIM_ACC_IDLE;
        else
            acc_reg <= acc_next;
    end

    // the read is finished on the first cycle in which the strobe is gone
    assign rd_hold = (acc_reg == GIM_ACC_READ);
    assign rd_done = rd_hold && !acc_cs;

    // an event on the snapshot edge would miss the snapshot and then be cleared, so it waits too
    assign rd_take = (acc_reg == GIM_ACC_IDLE) && acc_cs && !acc_we && hit_status;
    assign evt_hold = rd_take || rd_hold;

    ////////////////////////////////////////////////////////////////////////////
    // mask two, write-only

    gim_byte_t mask_two_reg;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            mask_two_reg <= `GIM_MASK_TWO_RST;
        else if (acc_reg == GIM_ACC_IDLE && acc_cs && acc_we && hit_mask)
        begin
            mask_two_reg <= acc_wdata;
            mask_two_reg[`GIM_M2_RSVD] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data-in flag of the first group

    logic lsn_take;
    logic rx_clear;
    logic rx_flag_reg;

    assign lsn_take = lsn.listener_active && lsn.accept_data && lsn.cont_listen;
    assign rx_clear = rd_status_one || rd_rx_data || (lsn.finish_hs_cmd && lsn.rfd_holdoff);

    // a byte taken in the same cycle as a clear still shows
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rx_flag_reg <= 1'b0;
        else if (lsn_take)
            rx_flag_reg <= 1'b1;
        else if (rx_clear)
            rx_flag_reg <= 1'b0;
    end

    assign rx_byte_flag = rx_flag_reg;

    ////////////////////////////////////////////////////////////////////////////
    // second group event bits

    localparam int NEVT = 5;
    logic [NEVT-1:0] evt_set;
    logic [NEVT-1:0] evt_flag;

    assign evt_set = {evt.svc_request_in, evt.cmd_byte_needed, evt.lockout_changed,
                      evt.rl_state_changed, evt.addr_state_changed};

    generate
        for (genvar i = 0; i < NEVT; i++)
        begin : g_evt
            gim_evt_bit u_bit (
                .sys_clk(sys_clk),
                .srst(srst),
                .set_evt(evt_set[i]),
                .hold(evt_hold),
                .rd_done(rd_done),
                .flag(evt_flag[i])
            );
        end
    endgenerate

    // state levels are frozen while a read is in progress
    logic lockout_reg;
    logic rl_state_reg;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            lockout_reg <= 1'b0;
            rl_state_reg <= 1'b0;
        end
        else if (!rd_hold)
        begin
            lockout_reg <= evt.lockout_flag;
            rl_state_reg <= evt.rl_state_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // summary interrupt

    logic [12:0] term;
    logic summary_reg;

    always_comb
    begin
        term[0] = grp_one.cmd_passthru && grp_one_en.cmd_passthru;
        term[1] = grp_one.addr_passthru && grp_one_en.addr_passthru;
        term[2] = grp_one.trigger_rx && grp_one_en.trigger_rx;
        term[3] = grp_one.err && grp_one_en.err;
        term[4] = grp_one.end_rx && grp_one_en.end_rx;
        term[5] = grp_one.clear_rx && grp_one_en.clear_rx;
        term[6] = grp_one.tx_byte_flag && grp_one_en.tx_byte_flag;
        term[7] = rx_flag_reg && rx_byte_flag_en;
        term[8] = evt_flag[4] && mask_two_reg[`GIM_M2_SVC_REQ_IN_EN];
        term[9] = evt_flag[1] && mask_two_reg[`GIM_M2_REM_CHG_EN];
        term[10] = evt_flag[3] && mask_two_reg[`GIM_M2_CMD_OUT_EN];
        term[11] = evt_flag[2] && mask_two_reg[`GIM_M2_LOK_CHG_EN];
        term[12] = evt_flag[0] && mask_two_reg[`GIM_M2_ADS_CHG_EN];
    end

    // registered so the request line never glitches; costs one cycle of latency
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            summary_reg <= 1'b0;
        else
            summary_reg <= |term;
    end

    assign irq_out = summary_reg;

    ////////////////////////////////////////////////////////////////////////////
    // DMA steering

    logic dma_rx_reg;
    logic dma_tx_reg;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            dma_rx_reg <= 1'b0;
            dma_tx_reg <= 1'b0;
        end
        else
        begin
            dma_rx_reg <= rx_flag_reg && mask_two_reg[`GIM_M2_DMA_RX_EN];
            dma_tx_reg <= grp_one.tx_byte_flag && mask_two_reg[`GIM_M2_DMA_TX_EN];
        end
    end

    assign dma_rx_req = dma_rx_reg;
    assign dma_tx_req = dma_tx_reg;

    ////////////////////////////////////////////////////////////////////////////
    // read data

    gim_byte_t status_two;
    gim_byte_t rdata_reg;

    always_comb
    begin
        status_two = `GIM_STATUS_RST;
        status_two[`GIM_S2_SUMMARY_BIT] = summary_reg;
        status_two[`GIM_S2_SVC_REQ_IN] = evt_flag[4];
        status_two[`GIM_S2_LOCKOUT] = lockout_reg;
        status_two[`GIM_S2_RL_STATE] = rl_state_reg;
        status_two[`GIM_S2_CMD_OUT] = evt_flag[3];
        status_two[`GIM_S2_LOK_CHG] = evt_flag[2];
        status_two[`GIM_S2_REM_CHG] = evt_flag[1];
        status_two[`GIM_S2_ADS_CHG] = evt_flag[0];
    end

    // snapshot taken once at the start of the read; the mask never reads back
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdata_reg <= `GIM_RDATA_RST;
        else if (acc_reg == GIM_ACC_IDLE && acc_cs && !acc_we)
            rdata_reg <= hit_status ? status_two : `GIM_RDATA_RST;
    end

    assign acc_rdata = rdata_reg;
    assign acc_rvalid = rd_hold;

endmodule

//--- gim_defines.svh
`ifndef GIM_DEFINES_SVH
`define GIM_DEFINES_SVH

// port-relative byte offsets
`define GIM_ADDR_W 12
`define GIM_OFS_STATUS_TWO 12'h115
`define GIM_OFS_MASK_TWO 12'h115

// status two bit positions
`define GIM_S2_SUMMARY_BIT 7
`define GIM_S2_SVC_REQ_IN 6
`define GIM_S2_LOCKOUT 5
`define GIM_S2_RL_STATE 4
`define GIM_S2_CMD_OUT 3
`define GIM_S2_LOK_CHG 2
`define GIM_S2_REM_CHG 1
`define GIM_S2_ADS_CHG 0

// mask two bit positions
`define GIM_M2_RSVD 7
`define GIM_M2_SVC_REQ_IN_EN 6
`define GIM_M2_DMA_TX_EN 5
`define GIM_M2_DMA_RX_EN 4
`define GIM_M2_CMD_OUT_EN 3
`define GIM_M2_LOK_CHG_EN 2
`define GIM_M2_REM_CHG_EN 1
`define GIM_M2_ADS_CHG_EN 0

// reset values
`define GIM_MASK_TWO_RST 8'h00
`define GIM_STATUS_RST 8'h00
`define GIM_RDATA_RST 8'h00

`endif

//--- gim_pkg.sv
package gim_pkg;

    typedef logic [7:0] gim_byte_t;

    // first status group terms held outside this block
    typedef struct packed {
        logic cmd_passthru;
        logic addr_passthru;
        logic trigger_rx;
        logic err;
        logic end_rx;
        logic clear_rx;
        logic tx_byte_flag;
    } gim_grp_one_s;

    // engine state feeding the data-in flag
    typedef struct packed {
        logic listener_active;
        logic accept_data;
        logic cont_listen;
        logic finish_hs_cmd;
        logic rfd_holdoff;
    } gim_lsn_s;

    // second group events (one-cycle pulses) and levels
    typedef struct packed {
        logic svc_request_in;
        logic cmd_byte_needed;
        logic lockout_changed;
        logic rl_state_changed;
        logic addr_state_changed;
        logic lockout_flag;
        logic rl_state_flag;
    } gim_evt_two_s;

    typedef enum logic [2:0] {
        GIM_ACC_IDLE = 3'b001,
        GIM_ACC_READ = 3'b010,
        GIM_ACC_WRITE = 3'b100
    } gim_acc_e;

endpackage

//--- gim_evt_bit.sv
`timescale 1ns/1ps
`include "gim_defines.svh"

module gim_evt_bit
    import gim_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic set_evt,
    input wire logic hold,
    input wire logic rd_done,
    output logic flag
);

    logic pend_reg;
    logic flag_reg;

    // an event seen while the register is being read waits here
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            pend_reg <= 1'b0;
        else if (rd_done)
            pend_reg <= 1'b0;
        else if (hold && set_evt)
            pend_reg <= 1'b1;
    end

    // set beats the read clear so an event is never lost
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            flag_reg <= 1'b0;
        else if (rd_done)
            flag_reg <= set_evt || pend_reg;
        else if (!hold && set_evt)
            flag_reg <= 1'b1;
    end

    assign flag = flag_reg;

endmodule

//--- gim_host.sv
`timescale 1ns/1ps
`include "gim_defines.svh"
module gim_host
    import gim_pkg::*;
(
    input wire logic sys_clk,
    input wire logic acc_rvalid,
    input wire gim_byte_t acc_rdata,
    output logic acc_cs,
    output logic acc_we,
    output logic [`GIM_ADDR_W-1:0] acc_addr,
    output gim_byte_t acc_wdata
);
    initial
    begin
        acc_cs = 1'b0;
        acc_we = 1'b0;
        acc_addr = 12'hEEA;
        acc_wdata = 8'hA5;
    end
    // released address lines show the inverse, so a stale address can never pass for a held one; wr holds d & 8'h7F but releases ~d
    task automatic wr(input logic [11:0] a, input gim_byte_t d);
        @(negedge sys_clk);
        acc_cs = 1'b1;
        acc_we = 1'b1;
        acc_addr = a;
        acc_wdata = d & 8'h7F;
        @(posedge sys_clk);
        @(negedge sys_clk);
        acc_cs = 1'b0;
        acc_addr = ~a;
        acc_wdata = ~d;
    endtask
    task automatic rd(input logic [11:0] a, input int hold, output gim_byte_t d);
        @(negedge sys_clk);
        acc_cs = 1'b1;
        acc_we = 1'b0;
        acc_addr = a;
        @(posedge sys_clk);
        repeat (hold) @(posedge sys_clk);
        d = acc_rdata;
        @(negedge sys_clk);
        acc_cs = 1'b0;
        acc_addr = ~a;
    endtask
endmodule

//--- gim_core_assertions.sv
`timescale 1ns/1ps
`include "gim_defines.svh"
module gim_core_assertions
    import gim_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic acc_cs,
    input wire logic acc_we,
    input wire logic [`GIM_ADDR_W-1:0] acc_addr,
    input wire gim_byte_t acc_rdata,
    input wire logic acc_rvalid,
    input wire logic rd_status_one,
    input wire logic rd_rx_data,
    input wire gim_lsn_s lsn,
    input wire gim_grp_one_s grp_one,
    input wire gim_grp_one_s grp_one_en,
    input wire logic rx_byte_flag_en,
    input wire logic rx_byte_flag,
    input wire logic dma_rx_req,
    input wire logic dma_tx_req,
    input wire logic irq_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_rd_start;
        $rose(acc_cs) && !acc_we && acc_addr == 12'h115;
    endsequence
    sequence s_other_rd;
        $rose(acc_cs) && !acc_we && acc_addr != 12'h115;
    endsequence
    a_rd_answer: assert property (s_rd_start |=> acc_rvalid) else $error("read not answered");
    a_rd_release: assert property (acc_rvalid && !acc_cs |=> !acc_rvalid) else $error("read not released");
    a_rd_hold: assert property (s_rd_start ##1 (acc_rvalid && acc_cs)[*2] |-> $stable(acc_rdata))
        else $error("read data moved during read");
    a_other_zero: assert property (s_other_rd |=> acc_rdata == 8'h00 && !acc_rvalid)
        else $error("other address answered");
    a_flag_set: assert property (lsn.listener_active && lsn.accept_data && lsn.cont_listen |=> rx_byte_flag)
        else $error("data-in flag not set");
    a_flag_clear: assert property ((rd_status_one || rd_rx_data || (lsn.finish_hs_cmd && lsn.rfd_holdoff))
        && !(lsn.listener_active && lsn.accept_data && lsn.cont_listen) |=> !rx_byte_flag)
        else $error("data-in flag not cleared");
    a_dma_rx_src: assert property (dma_rx_req |-> $past(rx_byte_flag)) else $error("dma rx without flag");
    a_dma_tx_src: assert property (dma_tx_req |-> $past(grp_one.tx_byte_flag)) else $error("dma tx without flag");
    a_irq_rx: assert property (rx_byte_flag && rx_byte_flag_en |=> irq_out) else $error("data-in irq missing");
    a_irq_one: assert property ((grp_one & grp_one_en) != 7'h00 |=> irq_out) else $error("group one irq missing");
endmodule
bind gim_core gim_core_assertions u_chk (.sys_clk, .srst, .acc_cs, .acc_we, .acc_addr, .acc_rdata, .acc_rvalid,
    .rd_status_one, .rd_rx_data, .lsn, .grp_one, .grp_one_en, .rx_byte_flag_en, .rx_byte_flag, .dma_rx_req,
    .dma_tx_req, .irq_out);

//--- gim_core_bench.sv
`timescale 1ns/1ps
`include "gim_defines.svh"
module gim_core_bench
    import gim_pkg::*;
    ();
    typedef struct packed {logic [6:0] g; logic [6:0] e; logic irq; logic dtx;} gim_row_s;
    localparam gim_row_s ROWS [10] = '{
        '{7'h40, 7'h40, 1'h1, 1'h0}, '{7'h20, 7'h20, 1'h1, 1'h0}, '{7'h10, 7'h10, 1'h1, 1'h0},
        '{7'h08, 7'h08, 1'h1, 1'h0}, '{7'h04, 7'h04, 1'h1, 1'h0}, '{7'h02, 7'h02, 1'h1, 1'h0},
        '{7'h01, 7'h01, 1'h1, 1'h1}, '{7'h7F, 7'h00, 1'h0, 1'h1}, '{7'h00, 7'h7F, 1'h0, 1'h0},
        '{7'h3E, 7'h41, 1'h0, 1'h0}};
    logic sys_clk = 0, srst = 1, acc_cs, acc_we, acc_rvalid, rd_status_one = 0, rd_rx_data = 0;
    logic rx_byte_flag_en = 0, rx_byte_flag, dma_rx_req, dma_tx_req, irq_out;
    logic [11:0] acc_addr;
    logic [1:0] lvl = 2'b00;
    gim_byte_t acc_wdata, acc_rdata, d;
    gim_lsn_s lsn = '0;
    gim_evt_two_s evt = '0;
    gim_grp_one_s grp_one = '0, grp_one_en = '0;
    int err_count = 0, n_checks = 0, cyc = 0;
    gim_core u_dut (.sys_clk(sys_clk), .srst(srst), .acc_cs(acc_cs), .acc_we(acc_we), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .rd_status_one(rd_status_one),
        .rd_rx_data(rd_rx_data), .lsn(lsn), .evt(evt), .grp_one(grp_one), .grp_one_en(grp_one_en),
        .rx_byte_flag_en(rx_byte_flag_en), .rx_byte_flag(rx_byte_flag), .dma_rx_req(dma_rx_req),
        .dma_tx_req(dma_tx_req), .irq_out(irq_out));
    gim_host u_host (.sys_clk(sys_clk), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata), .acc_cs(acc_cs),
        .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input gim_byte_t seen, input gim_byte_t exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    task automatic end_of_test();
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic nwait(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // event pulses ride on top of the two level bits
    task automatic evp(input logic [6:0] p);
        @(negedge sys_clk);
        evt = p | {5'b0, lvl};
        @(negedge sys_clk);
        evt = {5'b0, lvl};
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        nwait(10);
        srst = 0;
        chk("irq_out", irq_out, 8'h00);
        u_host.rd(12'h115, 1, d);
        chk("status_two_rst", d, 8'h00);
        u_host.wr(12'h115, 8'h20);
        foreach (ROWS[i])
        begin
            grp_one = ROWS[i].g;
            grp_one_en = ROWS[i].e;
            nwait(2);
            chk("irq_row", irq_out, ROWS[i].irq);
            chk("dma_tx_row", dma_tx_req, ROWS[i].dtx);
        end
        grp_one = '0;
        u_host.wr(12'h115, 8'h10);
        for (int k = 0; k < 3; k++)
        begin
            lsn = 5'b11100;
            nwait(1);
            lsn = '0;
            nwait(2);
            chk("rx_flag", rx_byte_flag, 8'h01);
            chk("dma_rx", dma_rx_req, 8'h01);
            chk("irq_dma", irq_out, rx_byte_flag_en);
            rx_byte_flag_en = 1;
            rd_status_one = (k == 0);
            rd_rx_data = (k == 1);
            lsn = (k == 2) ? 5'b00011 : 5'b00000;
            nwait(1);
            {rd_status_one, rd_rx_data, lsn} = '0;
            nwait(2);
            chk("rx_flag_clr", rx_byte_flag, 8'h00);
            chk("irq_clr", irq_out, 8'h00);
        end
        rx_byte_flag_en = 0;
        u_host.wr(12'h115, 8'h00);
        lvl = 2'b11;
        evp(7'h7C);
        nwait(2);
        u_host.rd(12'h115, 1, d);
        chk("status_two", d, 8'h7F);
        u_host.rd(12'h115, 1, d);
        chk("status_two_clr", d, 8'h30);
        u_host.wr(12'h115, 8'h40);
        evp(7'h40);
        nwait(3);
        chk("irq_svc", irq_out, 8'h01);
        u_host.rd(12'h115, 1, d);
        chk("status_two_sum", d, 8'hF0);
        nwait(2);
        chk("irq_svc_clr", irq_out, 8'h00);
        fork
            u_host.rd(12'h115, 4, d);
            begin
                nwait(2);
                evp(7'h04);
            end
        join
        chk("status_two_snap", d, 8'h30);
        u_host.rd(12'h114, 1, d);
        chk("other_addr", d, 8'h00);
        u_host.rd(12'h115, 1, d);
        chk("status_two_held", d, 8'h31);
        srst = 1;
        nwait(2);
        srst = 0;
        evp(7'h40);
        nwait(3);
        chk("irq_after_rst", irq_out, 8'h00);
        end_of_test();
    end
endmodule
